// ---- common/irq_bridge_pkg.sv ----
/*
  Shared constants of the bridge interrupt channel: register offsets,
  source bit positions, reset values and bus answer codes.
  Assumes both ends and the register bus run on one clock.
*/
package irq_bridge_pkg;

  // source bit positions, shared by enable, routing, status and origin words
  localparam int NUM_SRC = 24;
  localparam int SRC_PCI_IRQ = 0;
  localparam int SRC_PARITY_ERR = 1;
  localparam int SRC_SYSTEM_ERR = 2;
  localparam int SRC_LOCAL_IRQ = 3;
  localparam int SRC_PCI_ERR_LOG = 4;
  localparam int SRC_MASTER_PARITY = 5;
  localparam int SRC_LOCAL_ERR_LOG = 6;
  localparam int SRC_DMA_LOCAL_ERR = 7;
  localparam int SRC_DMA_PCI_ERR = 8;
  localparam int SRC_DMA_RESET = 9;
  localparam int SRC_DMA_DONE = 10;
  localparam int SRC_PCI_STATUS = 11;
  localparam int SRC_MAILBOX0 = 12;
  localparam int NUM_MAILBOX = 4;
  localparam int SRC_LOCAL_PARITY = 16;
  localparam int SRC_POWER_CHANGE = 17;
  localparam int SRC_QUEUE0 = 18;
  localparam int NUM_QUEUE = 6;
  localparam int NUM_DMA_EVT = 4;
  // routing word bit that selects the hardware pin direction
  localparam int HW_DIR_BIT = 24;

  // register byte offsets
  localparam logic [3:0] OFS_ENABLE = 4'h0;
  localparam logic [3:0] OFS_ROUTE = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_ORIGIN = 4'hc;

  // values after reset
  localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_ROUTE = 32'h0000_0000;
  localparam logic [31:0] RST_STATUS = 32'h0000_0000;
  localparam logic [31:0] RST_ORIGIN = 32'h0000_0000;

  // writable and clearable bits
  localparam logic [31:0] MASK_ENABLE = 32'h00ff_ffff;
  localparam logic [31:0] MASK_ROUTE = 32'h01ff_fff0;
  localparam logic [31:0] MASK_ORIGIN = 32'h0002_0ff0;

  // axi answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : irq_bridge_pkg

// ---- common/irq_pins_if.sv ----
/*
  Interrupt pins between the bridge and the outside party: the two-way
  active-low lines pci_int_n and local_irq_line, and the error inputs
  parity_err_n and system_err_n. Each end drives low through its enable.
  Assumes an external pull-up; each receiver sees the other end's drive.
*/
`timescale 1ns/1ps
interface irq_pins_if;
  // bridge drive
  logic pci_int_dev_o;
  logic pci_int_dev_oe;
  logic local_irq_line_dev_o;
  logic local_irq_line_dev_oe;
  // outside party drive
  logic pci_int_far_o;
  logic pci_int_far_oe;
  logic local_irq_line_far_o;
  logic local_irq_line_far_oe;
  logic parity_err_far_o;
  logic parity_err_far_oe;
  logic system_err_far_o;
  logic system_err_far_oe;
  // receiver levels
  logic pci_int_dev_i;
  logic local_irq_line_dev_i;
  logic parity_err_dev_i;
  logic system_err_dev_i;
  logic pci_int_far_i;
  logic local_irq_line_far_i;
  // resolved wire levels
  logic pci_int_n;
  logic local_irq_line_n;

  assign pci_int_dev_i = pci_int_far_oe ? pci_int_far_o : 1'b1;
  assign local_irq_line_dev_i = local_irq_line_far_oe ? local_irq_line_far_o : 1'b1;
  assign parity_err_dev_i = parity_err_far_oe ? parity_err_far_o : 1'b1;
  assign system_err_dev_i = system_err_far_oe ? system_err_far_o : 1'b1;
  assign pci_int_far_i = pci_int_dev_oe ? pci_int_dev_o : 1'b1;
  assign local_irq_line_far_i = local_irq_line_dev_oe ? local_irq_line_dev_o : 1'b1;
  assign pci_int_n = pci_int_dev_i & pci_int_far_i;
  assign local_irq_line_n = local_irq_line_dev_i & local_irq_line_far_i;

  modport dev (
    input pci_int_dev_i, local_irq_line_dev_i, parity_err_dev_i, system_err_dev_i,
    output pci_int_dev_o, pci_int_dev_oe, local_irq_line_dev_o, local_irq_line_dev_oe
  );
  modport far (
    input pci_int_far_i, local_irq_line_far_i,
    output pci_int_far_o, pci_int_far_oe, local_irq_line_far_o, local_irq_line_far_oe,
    output parity_err_far_o, parity_err_far_oe, system_err_far_o, system_err_far_oe
  );
endinterface : irq_pins_if

// ---- dv/bridge_interrupt_channel_checker.sv ----
/*
  Pin-level assertions and covers for the bridge interrupt channel.
  Assumes it sits beside irq_pins_if, sampling on aclk with aresetn.
*/
`timescale 1ns/1ps
module bridge_interrupt_channel_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bridge drive
  input wire logic pci_int_dev_o,
  input wire logic pci_int_dev_oe,
  input wire logic local_irq_line_dev_o,
  input wire logic local_irq_line_dev_oe,
  // outside party drive
  input wire logic pci_int_far_oe,
  input wire logic local_irq_line_far_oe,
  input wire logic parity_err_far_oe,
  input wire logic system_err_far_oe
);
  logic err_far;
  logic pci_side_far;
  assign err_far = parity_err_far_oe | system_err_far_oe;
  assign pci_side_far = pci_int_far_oe | err_far;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_int_pull_low: assert property (pci_int_dev_oe |-> !pci_int_dev_o)
    else $error("bridge drives the pci interrupt wire high");
  chk_local_pull_low: assert property (local_irq_line_dev_oe |-> !local_irq_line_dev_o)
    else $error("bridge drives the local interrupt wire high");
  chk_local_held_pin: assert property ((pci_int_far_oe && local_irq_line_dev_oe) ##1
    pci_int_far_oe |-> local_irq_line_dev_oe)
    else $error("local line dropped while pci interrupt still asserted");
  chk_local_held_err: assert property ((err_far && local_irq_line_dev_oe) ##1 err_far
    |-> local_irq_line_dev_oe)
    else $error("local line dropped while error pin still asserted");
  chk_int_held_local: assert property ((local_irq_line_far_oe && pci_int_dev_oe) ##1
    local_irq_line_far_oe |-> pci_int_dev_oe)
    else $error("pci interrupt dropped while local line still asserted");
  chk_local_release: assert property ($fell(local_irq_line_dev_oe) |->
    !$past(pci_side_far, 3))
    else $error("local line released too soon after pci side pin");
  chk_int_release: assert property ($fell(pci_int_dev_oe) |->
    !$past(local_irq_line_far_oe, 3))
    else $error("pci interrupt released too soon after local line");
  chk_reset_idle: assert property ($rose(aresetn) |->
    !pci_int_dev_oe && !local_irq_line_dev_oe)
    else $error("interrupt wire driven right after reset");

  cov_local_raised: cover property ($rose(local_irq_line_dev_oe));
  cov_int_raised: cover property ($rose(pci_int_dev_oe));
  cov_int_from_local: cover property (local_irq_line_far_oe && pci_int_dev_oe);
endmodule : bridge_interrupt_channel_checker

// ---- dv/test_bridge_interrupt_channel.sv ----
/*
  Self-checking bench: both ends joined by irq_pins_if, registers over AXI4-Lite.
  Assumes aclk at 50 MHz and a register slave that answers in its own time.
*/
`timescale 1ns/1ps
module test_bridge_interrupt_channel;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hf, mb_pci = 4'h0, req = 4'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, pci_int_seen, local_irq_seen;
  logic [1:0] s_bresp, s_rresp;
  logic [23:0] ev = 24'h0;
  int err_total = 0, compares = 0, cyc = 0, seed = 64;
  logic en, dir, fp, q, fl, exp_s;
  logic [31:0] m, d;

  always #10 aclk = ~aclk;
  irq_pins_if i_irq_pins_if ();
  irq_bridge_dev i_irq_bridge_dev (.aclk(aclk), .aresetn(aresetn), .pins(i_irq_pins_if),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .pci_err_log_evt(ev[4]), .master_parity_detect(ev[5]),
    .local_err_log_evt(ev[6]), .dma_evt(ev[10:7]), .pci_status_evt(ev[11]),
    .mailbox_wr(ev[15:12]), .local_parity_evt(ev[16]), .power_change_evt(ev[17]),
    .mailbox_wr_from_pci(mb_pci), .queue_cond(ev[23:18]));
  irq_bridge_far i_irq_bridge_far (.aclk(aclk), .aresetn(aresetn), .pins(i_irq_pins_if),
    .pci_irq_req(req[0]), .parity_err_req(req[1]), .system_err_req(req[2]),
    .local_irq_req(req[3]), .pci_int_seen(pci_int_seen), .local_irq_seen(local_irq_seen));
  bridge_interrupt_channel_checker i_bridge_interrupt_channel_checker (.aclk(aclk),
    .aresetn(aresetn), .pci_int_dev_o(i_irq_pins_if.pci_int_dev_o),
    .pci_int_dev_oe(i_irq_pins_if.pci_int_dev_oe),
    .local_irq_line_dev_o(i_irq_pins_if.local_irq_line_dev_o),
    .local_irq_line_dev_oe(i_irq_pins_if.local_irq_line_dev_oe),
    .pci_int_far_oe(i_irq_pins_if.pci_int_far_oe),
    .local_irq_line_far_oe(i_irq_pins_if.local_irq_line_far_oe),
    .parity_err_far_oe(i_irq_pins_if.parity_err_far_oe),
    .system_err_far_oe(i_irq_pins_if.system_err_far_oe));

  task automatic results();
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_bit

  // mailboxes interrupt only on writes from the side opposite their route
  function automatic logic exp_pending(input int b, input logic en, input logic dir,
    input logic fp);
    return en && (b < irq_bridge_pkg::SRC_MAILBOX0
      || b >= irq_bridge_pkg::SRC_MAILBOX0 + irq_bridge_pkg::NUM_MAILBOX || fp != dir);
  endfunction : exp_pending

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] wd);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= wd;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
    cmp_word({30'h0, s_bresp}, {30'h0, irq_bridge_pkg::RESP_OKAY});
  endtask : axi_wr

  task automatic rd_cmp(input logic [3:0] a, input logic [31:0] exp);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    s_rready <= 1'b0;
    cmp_word(s_rdata, exp);
    cmp_word({30'h0, s_rresp}, {30'h0, irq_bridge_pkg::RESP_OKAY});
  endtask : rd_cmp

  // pin sync plus seen path take about ten edges
  task automatic settle();
    repeat (12) @(posedge aclk);
  endtask : settle

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      results();
    end
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_cmp(irq_bridge_pkg::OFS_ENABLE, irq_bridge_pkg::RST_ENABLE);
    rd_cmp(irq_bridge_pkg::OFS_ROUTE, irq_bridge_pkg::RST_ROUTE);
    rd_cmp(irq_bridge_pkg::OFS_STATUS, irq_bridge_pkg::RST_STATUS);
    rd_cmp(irq_bridge_pkg::OFS_ORIGIN, irq_bridge_pkg::RST_ORIGIN);
    repeat (4) begin
      d = $random(seed);
      axi_wr(irq_bridge_pkg::OFS_ENABLE, d);
      axi_wr(irq_bridge_pkg::OFS_ROUTE, d);
      rd_cmp(irq_bridge_pkg::OFS_ENABLE, d & irq_bridge_pkg::MASK_ENABLE);
      rd_cmp(irq_bridge_pkg::OFS_ROUTE, d & irq_bridge_pkg::MASK_ROUTE);
      // one byte lane only: the other lanes keep their value
      s_wstrb <= 4'h2;
      axi_wr(irq_bridge_pkg::OFS_ENABLE, ~d);
      s_wstrb <= 4'hf;
      rd_cmp(irq_bridge_pkg::OFS_ENABLE, ((d & 32'hffff_00ff) | (~d & 32'h0000_ff00))
        & irq_bridge_pkg::MASK_ENABLE);
    end
    // internal sources: flags, mailboxes, local parity, queue levels
    for (int b = 4; b < 24; b++) begin
      d = $random(seed);
      en = d[0];
      dir = d[1];
      fp = d[2];
      q = (b >= 18);
      fl = (b < 12) || (b == 17);
      m = 32'h1 << b;
      exp_s = exp_pending(b, en, dir, fp);
      axi_wr(irq_bridge_pkg::OFS_ENABLE, en ? m : 32'h0);
      axi_wr(irq_bridge_pkg::OFS_ROUTE, dir ? m : 32'h0);
      mb_pci <= {4{fp}};
      ev <= m[23:0];
      @(posedge aclk);
      if (!q) ev <= 24'h0;
      settle();
      rd_cmp(irq_bridge_pkg::OFS_ORIGIN, (q || fl) ? m : 32'h0);
      rd_cmp(irq_bridge_pkg::OFS_STATUS, exp_s ? m : 32'h0);
      cmp_bit(pci_int_seen, exp_s & dir);
      cmp_bit(local_irq_seen, exp_s & ~dir);
      axi_wr(irq_bridge_pkg::OFS_STATUS, 32'h00ff_ffff);
      axi_wr(irq_bridge_pkg::OFS_ORIGIN, 32'h0);
      rd_cmp(irq_bridge_pkg::OFS_STATUS, (exp_s && (q || fl)) ? m : 32'h0);
      rd_cmp(irq_bridge_pkg::OFS_ORIGIN, (q || fl) ? m : 32'h0);
      if (q) ev <= 24'h0;
      else axi_wr(irq_bridge_pkg::OFS_ORIGIN, m);
      settle();
      rd_cmp(irq_bridge_pkg::OFS_ORIGIN, 32'h0);
      axi_wr(irq_bridge_pkg::OFS_STATUS, m);
      settle();
      rd_cmp(irq_bridge_pkg::OFS_STATUS, 32'h0);
      cmp_bit(pci_int_seen, 1'b0);
      cmp_bit(local_irq_seen, 1'b0);
    end
    // pci side pins toward the local line, local pin held against the direction
    for (int p = 0; p < 3; p++) begin
      axi_wr(irq_bridge_pkg::OFS_ROUTE, 32'h0);
      axi_wr(irq_bridge_pkg::OFS_ENABLE, 32'h0);
      req <= (4'h1 << p) | 4'h8;
      settle();
      rd_cmp(irq_bridge_pkg::OFS_STATUS, 32'h0);
      cmp_bit(local_irq_seen, 1'b0);
      axi_wr(irq_bridge_pkg::OFS_ENABLE, 32'hf);
      settle();
      rd_cmp(irq_bridge_pkg::OFS_STATUS, 32'h1 << p);
      cmp_bit(local_irq_seen, 1'b1);
      cmp_bit(pci_int_seen, 1'b0);
      axi_wr(irq_bridge_pkg::OFS_STATUS, 32'hf);
      settle();
      rd_cmp(irq_bridge_pkg::OFS_STATUS, 32'h1 << p);
      req <= 4'h0;
      settle();
      cmp_bit(local_irq_seen, 1'b1);
      axi_wr(irq_bridge_pkg::OFS_STATUS, 32'hf);
      settle();
      cmp_bit(local_irq_seen, 1'b0);
      rd_cmp(irq_bridge_pkg::OFS_STATUS, 32'h0);
    end
    // local line toward the pci interrupt, pci pin held against the direction
    axi_wr(irq_bridge_pkg::OFS_ROUTE, 32'h0100_0000);
    req <= 4'h9;
    settle();
    rd_cmp(irq_bridge_pkg::OFS_STATUS, 32'h8);
    cmp_bit(pci_int_seen, 1'b1);
    cmp_bit(local_irq_seen, 1'b0);
    axi_wr(irq_bridge_pkg::OFS_STATUS, 32'hf);
    settle();
    cmp_bit(pci_int_seen, 1'b1);
    req <= 4'h1;
    settle();
    cmp_bit(pci_int_seen, 1'b1);
    axi_wr(irq_bridge_pkg::OFS_STATUS, 32'hf);
    settle();
    cmp_bit(pci_int_seen, 1'b0);
    rd_cmp(irq_bridge_pkg::OFS_STATUS, 32'h0);
    req <= 4'h0;
    settle();
    results();
  end
endmodule : test_bridge_interrupt_channel

// ---- hw/irq_bridge_dev.sv ----
/*
  Bridge end of the interrupt channel: forwards pin interrupts across the
  bridge, raises interrupts from internal events, AXI4-Lite register slave.
  Assumes pins through irq_pins_if.dev, event pulses one cycle wide on aclk.
// Function
// R1: forward pin input only while enabled
// R2: forwarded pin input sets its status bit
// R3: pin forwarding in one direction only
// R4: pci side pins drive local line; local drives INT
// R5: local line held until INT negated, status cleared
// R6: INT level sensitive, early clear has no effect
// R7: error pin status stays until source negated
// R8: INT held until local line negated, status cleared
// R9: internal event interrupts only when enabled
// R10: routing bit picks INT or local line
// R11: every source has a readable status bit
// R12: status not cleared while origin still set
// R13: dma reset, done, errors are separate sources
// R14: origin flags clear on write one
// R15: pci error log and parity sources exist
// R16: six message queue condition sources
// R17: mailbox interrupts only on opposite side writes
// R18: status bit clears on write one
// R19: outputs follow pending enabled routed sources
*/
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module irq_bridge_dev #(
  parameter int NS = irq_bridge_pkg::NUM_SRC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins
  irq_pins_if.dev pins,
  // axi4-lite write
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // internal event sources
  input wire logic pci_err_log_evt,
  input wire logic master_parity_detect,
  input wire logic local_err_log_evt,
  input wire logic [irq_bridge_pkg::NUM_DMA_EVT-1:0] dma_evt,
  input wire logic pci_status_evt,
  input wire logic local_parity_evt,
  input wire logic power_change_evt,
  input wire logic [irq_bridge_pkg::NUM_MAILBOX-1:0] mailbox_wr,
  input wire logic [irq_bridge_pkg::NUM_MAILBOX-1:0] mailbox_wr_from_pci,
  input wire logic [irq_bridge_pkg::NUM_QUEUE-1:0] queue_cond
);
  logic pci_int_lvl;
  logic parity_err_lvl;
  logic system_err_lvl;
  logic local_irq_lvl;
  logic [31:0] irq_enable_reg_ff;
  logic [31:0] route_ff;
  logic [NS-1:0] status_ff;
  logic [NS-1:0] nxt_status;
  logic [NS-1:0] origin_ff;
  logic [NS-1:0] nxt_origin;
  logic [NS-1:0] origin_set;
  logic [NS-1:0] origin;
  logic [NS-1:0] pulse;
  logic [NS-1:0] enable;
  logic [NS-1:0] to_pci;
  logic [NS-1:0] live;
  logic [NS-1:0] status_clr;
  logic [NS-1:0] origin_clr;
  logic hw_dir;
  logic [3:0] hw_act;
  logic pci_int_oe_ff;
  logic local_irq_oe_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_exec;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [31:0] rd_word;
  logic rd_hit;

  // pin receivers
  pin_sync3 #(.IDLE(1'b1)) u_sync_int (.aclk(aclk), .aresetn(aresetn),
    .pin(pins.pci_int_dev_i), .level(pci_int_lvl));
  pin_sync3 #(.IDLE(1'b1)) u_sync_perr (.aclk(aclk), .aresetn(aresetn),
    .pin(pins.parity_err_dev_i), .level(parity_err_lvl));
  pin_sync3 #(.IDLE(1'b1)) u_sync_serr (.aclk(aclk), .aresetn(aresetn),
    .pin(pins.system_err_dev_i), .level(system_err_lvl));
  pin_sync3 #(.IDLE(1'b1)) u_sync_local (.aclk(aclk), .aresetn(aresetn),
    .pin(pins.local_irq_line_dev_i), .level(local_irq_lvl));

  assign hw_dir = route_ff[irq_bridge_pkg::HW_DIR_BIT];
  assign enable = irq_enable_reg_ff[NS-1:0];

  // pin inputs count only in the selected direction
  assign hw_act[irq_bridge_pkg::SRC_PCI_IRQ] = ~pci_int_lvl & ~hw_dir; // see R3, R4
  assign hw_act[irq_bridge_pkg::SRC_PARITY_ERR] = ~parity_err_lvl & ~hw_dir; // see R4
  assign hw_act[irq_bridge_pkg::SRC_SYSTEM_ERR] = ~system_err_lvl & ~hw_dir; // see R4
  assign hw_act[irq_bridge_pkg::SRC_LOCAL_IRQ] = ~local_irq_lvl & hw_dir; // see R3, R4

  // origin flags set by events
  always_comb begin
    origin_set = '0;
    origin_set[irq_bridge_pkg::SRC_PCI_ERR_LOG] = pci_err_log_evt; // see R15
    origin_set[irq_bridge_pkg::SRC_MASTER_PARITY] = master_parity_detect; // see R15
    origin_set[irq_bridge_pkg::SRC_LOCAL_ERR_LOG] = local_err_log_evt;
    for (int k = 0; k < irq_bridge_pkg::NUM_DMA_EVT; k++) begin
      origin_set[irq_bridge_pkg::SRC_DMA_LOCAL_ERR + k] = dma_evt[k]; // see R13
    end
    origin_set[irq_bridge_pkg::SRC_PCI_STATUS] = pci_status_evt;
    origin_set[irq_bridge_pkg::SRC_POWER_CHANGE] = power_change_evt;
  end

  // pulse sources with no origin flag
  always_comb begin
    pulse = '0;
    pulse[irq_bridge_pkg::SRC_LOCAL_PARITY] = local_parity_evt;
    for (int k = 0; k < irq_bridge_pkg::NUM_MAILBOX; k++) begin
      pulse[irq_bridge_pkg::SRC_MAILBOX0 + k] = mailbox_wr[k]
        & (mailbox_wr_from_pci[k] ^ route_ff[irq_bridge_pkg::SRC_MAILBOX0 + k]); // see R17
    end
  end

  // level origin of every source
  always_comb begin
    origin = origin_ff;
    origin[3:0] = hw_act;
    for (int k = 0; k < irq_bridge_pkg::NUM_QUEUE; k++) begin
      origin[irq_bridge_pkg::SRC_QUEUE0 + k] = queue_cond[k]; // see R16
    end
  end

  // routing per source
  always_comb begin
    to_pci = route_ff[NS-1:0]; // see R10
    to_pci[2:0] = 3'h0; // see R4
    to_pci[irq_bridge_pkg::SRC_LOCAL_IRQ] = 1'b1; // see R4
    live = {NS{1'b1}};
    live[2:0] = {3{~hw_dir}}; // see R3
    live[irq_bridge_pkg::SRC_LOCAL_IRQ] = hw_dir; // see R3
  end

  // register write decode
  assign wr_exec = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign wbits = wdata_ff & wmask;
  assign status_clr = (wr_exec && awaddr_ff == irq_bridge_pkg::OFS_STATUS)
    ? wbits[NS-1:0] : '0; // see R18
  assign origin_clr = (wr_exec && awaddr_ff == irq_bridge_pkg::OFS_ORIGIN)
    ? wbits[NS-1:0] & irq_bridge_pkg::MASK_ORIGIN[NS-1:0] : '0; // see R14

  // set wins over clear; clear refused while origin stands
  assign nxt_origin = (origin_ff & ~origin_clr) | origin_set; // see R14
  assign nxt_status = (status_ff & ~(status_clr & ~origin)) // see R5, R6, R7, R8, R12
    | ((origin | pulse) & enable); // see R1, R2, R9

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      origin_ff <= irq_bridge_pkg::RST_ORIGIN[NS-1:0];
      status_ff <= irq_bridge_pkg::RST_STATUS[NS-1:0];
    end else begin
      origin_ff <= nxt_origin;
      status_ff <= nxt_status; // see R11, R13
    end
  end

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_reg_ff <= irq_bridge_pkg::RST_ENABLE;
      route_ff <= irq_bridge_pkg::RST_ROUTE;
    end else if (wr_exec) begin
      if (awaddr_ff == irq_bridge_pkg::OFS_ENABLE) begin
        irq_enable_reg_ff <= ((irq_enable_reg_ff & ~wmask) | wbits)
          & irq_bridge_pkg::MASK_ENABLE;
      end
      if (awaddr_ff == irq_bridge_pkg::OFS_ROUTE) begin
        route_ff <= ((route_ff & ~wmask) | wbits) & irq_bridge_pkg::MASK_ROUTE;
      end
    end
  end

  // interrupt outputs, driven low while pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pci_int_oe_ff <= 1'b0;
      local_irq_oe_ff <= 1'b0;
    end else begin
      pci_int_oe_ff <= |(nxt_status & enable & live & to_pci); // see R1, R8, R19
      local_irq_oe_ff <= |(nxt_status & enable & live & ~to_pci); // see R1, R5, R19
    end
  end

  assign pins.pci_int_dev_o = 1'b0;
  assign pins.pci_int_dev_oe = pci_int_oe_ff;
  assign pins.local_irq_line_dev_o = 1'b0;
  assign pins.local_irq_line_dev_oe = local_irq_oe_ff;

  // axi write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= irq_bridge_pkg::RESP_OKAY;
    end else begin
      if (s_awvalid && awready_ff) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= {s_awaddr[3:2], 2'h0};
        awready_ff <= 1'b0;
      end
      if (s_wvalid && wready_ff) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_wdata;
        wstrb_ff <= s_wstrb;
        wready_ff <= 1'b0;
      end
      if (wr_exec) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
        bvalid_ff <= 1'b1;
        bresp_ff <= irq_bridge_pkg::RESP_OKAY;
      end else if (bvalid_ff && s_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case ({s_araddr[3:2], 2'h0})
      irq_bridge_pkg::OFS_ENABLE: rd_word = irq_enable_reg_ff;
      irq_bridge_pkg::OFS_ROUTE: rd_word = route_ff;
      irq_bridge_pkg::OFS_STATUS: rd_word[NS-1:0] = status_ff; // see R11
      irq_bridge_pkg::OFS_ORIGIN: rd_word[NS-1:0] = origin;
      default: rd_hit = 1'b0;
    endcase
  end

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= irq_bridge_pkg::RESP_OKAY;
    end else if (s_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_hit ? irq_bridge_pkg::RESP_OKAY : irq_bridge_pkg::RESP_SLVERR;
    end else if (rvalid_ff && s_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign s_awready = awready_ff;
  assign s_wready = wready_ff;
  assign s_bvalid = bvalid_ff;
  assign s_bresp = bresp_ff;
  assign s_arready = arready_ff;
  assign s_rvalid = rvalid_ff;
  assign s_rdata = rdata_ff;
  assign s_rresp = rresp_ff;
endmodule : irq_bridge_dev

// ---- hw/irq_bridge_far.sv ----
/*
  Outside party of the interrupt channel: pci host and local processor
  side. Drives the pins on user request and reports what the bridge drives.
  Assumes irq_pins_if.far and level requests on aclk.
*/
`timescale 1ns/1ps
module irq_bridge_far (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins
  irq_pins_if.far pins,
  // user requests, high to pull the pin low
  input wire logic pci_irq_req,
  input wire logic parity_err_req,
  input wire logic system_err_req,
  input wire logic local_irq_req,
  // bridge drive seen, high while asserted
  output logic pci_int_seen,
  output logic local_irq_seen
);
  logic pci_irq_oe_ff;
  logic parity_oe_ff;
  logic system_oe_ff;
  logic local_oe_ff;
  logic int_lvl;
  logic local_lvl;
  logic int_seen_ff;
  logic local_seen_ff;

  // pins held while requested; source negates before status clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pci_irq_oe_ff <= 1'b0;
      parity_oe_ff <= 1'b0;
      system_oe_ff <= 1'b0;
      local_oe_ff <= 1'b0;
    end else begin
      pci_irq_oe_ff <= pci_irq_req;
      parity_oe_ff <= parity_err_req; // see R7
      system_oe_ff <= system_err_req; // see R7
      local_oe_ff <= local_irq_req; // see R8
    end
  end

  pin_sync3 #(.IDLE(1'b1)) u_sync_int (.aclk(aclk), .aresetn(aresetn),
    .pin(pins.pci_int_far_i), .level(int_lvl));
  pin_sync3 #(.IDLE(1'b1)) u_sync_local (.aclk(aclk), .aresetn(aresetn),
    .pin(pins.local_irq_line_far_i), .level(local_lvl));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_seen_ff <= 1'b0;
      local_seen_ff <= 1'b0;
    end else begin
      int_seen_ff <= ~int_lvl;
      local_seen_ff <= ~local_lvl;
    end
  end

  assign pins.pci_int_far_o = 1'b0;
  assign pins.pci_int_far_oe = pci_irq_oe_ff;
  assign pins.parity_err_far_o = 1'b0;
  assign pins.parity_err_far_oe = parity_oe_ff;
  assign pins.system_err_far_o = 1'b0;
  assign pins.system_err_far_oe = system_oe_ff;
  assign pins.local_irq_line_far_o = 1'b0;
  assign pins.local_irq_line_far_oe = local_oe_ff;
  assign pci_int_seen = int_seen_ff;
  assign local_irq_seen = local_seen_ff;
endmodule : irq_bridge_far

// ---- hw/pin_sync3.sv ----
/*
  Three-stage pin synchroniser with agreement filter: the output follows
  once the second and third stages agree.
  Assumes an asynchronous pin input and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module pin_sync3 #(
  parameter logic IDLE = 1'b1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pin and filtered level
  input wire logic pin,
  output logic level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= IDLE;
      s2_ff <= IDLE;
      s3_ff <= IDLE;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_ff <= IDLE;
    end else if (s2_ff == s3_ff) begin
      level_ff <= s3_ff;
    end
  end

  assign level = level_ff;
endmodule : pin_sync3
